// ===== design/snc_top.sv
// Sleep noise canceler: converter control that starts a conversion when
// the core halts in idle or noise-reduction sleep, and wakes it after.
// Assumes core-side inputs share SYS_CLK; analog result arrives on a pin.
`timescale 1ns/100ps
`default_nettype none
`include "snc_cfg.svh"
module snc_top
  import snc_pkg::*;
#(
  parameter int PRESCALE = `SNC_PRESCALE
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SRST,
  input  wire logic                  CONVERTER_ENABLE_BIT,
  input  wire logic                  FREE_RUN,
  input  wire logic                  DONE_IRQ_ENABLE,
  input  wire logic                  START_WRITE,
  input  wire logic                  CORE_HALTED,
  input  wire logic [2:0]            SLEEP_SEL,
  input  wire logic                  OTHER_WAKE,
  input  wire logic                  DONE_FLAG_CLEAR,
  input  wire logic [`SNC_RES_W-1:0] ANALOG_SAMPLE,
  output logic                       CONVERSION_START_BIT,
  output logic                       CONVERSION_DONE_FLAG,
  output logic                       DONE_IRQ,
  output logic                       CORE_WAKE,
  output logic                       CONVERTER_ACTIVE,
  output logic [`SNC_RES_W-1:0]      RESULT
);
  import snc_pkg::*;

  // ==========================================================
  // Converter clock enable
  logic tick;
  snc_tick_div #(.DIV(PRESCALE)) u_div (
    .clk  (SYS_CLK),
    .rst  (SRST),
    .tick (tick)
  );

  // ==========================================================
  // Pin synchroniser for the analog sample bus
  // Word kept only after two equal samples, so bit skew never lands
  logic [`SNC_RES_W-1:0] samp_s1_reg;
  logic [`SNC_RES_W-1:0] samp_s2_reg;
  logic [`SNC_RES_W-1:0] samp_s3_reg;
  logic [`SNC_RES_W-1:0] samp_hold_reg;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      samp_s1_reg <= '0;
      samp_s2_reg <= '0;
      samp_s3_reg <= '0;
    end else begin
      samp_s1_reg <= ANALOG_SAMPLE;
      samp_s2_reg <= samp_s1_reg;
      samp_s3_reg <= samp_s2_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      samp_hold_reg <= '0;
    end else if (samp_s2_reg == samp_s3_reg) begin
      samp_hold_reg <= samp_s2_reg;
    end
  end

  // ==========================================================
  // Sleep trigger
  logic nr_sleep;
  logic halt_d_reg;
  logic sleep_trig;
  logic sleep_conv_reg;
  assign nr_sleep = CORE_HALTED &&
                    (SLEEP_SEL == `SNC_SLEEP_IDLE ||
                     SLEEP_SEL == `SNC_SLEEP_NRED);
  // Edge of the halt, so one sleep gives one conversion
  assign sleep_trig = nr_sleep && !halt_d_reg && CONVERTER_ENABLE_BIT
                      && !CONVERSION_START_BIT;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      halt_d_reg <= 1'b0;
    end else begin
      halt_d_reg <= nr_sleep;
    end
  end

  // ==========================================================
  // Conversion sequencer
  snc_state_t state_reg;
  logic [4:0] cyc_reg;
  logic       first_reg;
  logic       pend_reg;
  logic       complete;
  logic       kick;
  assign kick = START_WRITE || sleep_trig;
  assign complete = (state_reg == SNC_CONV) && tick && cyc_reg == 5'h01;

  // Start waits for a converter tick; start bit or a same-cycle kick holds the request
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !CONVERTER_ENABLE_BIT) begin
      state_reg <= SNC_IDLE;
      cyc_reg   <= 5'h00;
    end else begin
      unique case (state_reg)
        SNC_IDLE: begin
          if ((CONVERSION_START_BIT || kick) && tick) begin
            state_reg <= SNC_CONV;
            cyc_reg   <= first_reg ? 5'(`SNC_CONV_FIRST)
                                   : 5'(`SNC_CONV_NORMAL);
          end
        end
        SNC_CONV: begin
          if (tick) begin
            cyc_reg <= cyc_reg - 5'h01;
            if (cyc_reg == 5'h01) begin
              state_reg <= SNC_DONE;
            end
          end
        end
        SNC_DONE: begin
          state_reg <= SNC_IDLE;
        end
      endcase
    end
  end

  // Extended first conversion after every enable; toggle to recalibrate
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !CONVERTER_ENABLE_BIT) begin
      first_reg <= 1'b1;
    end else if (complete) begin
      first_reg <= 1'b0;
    end
  end

  // Enable is never cleared here for other sleep states
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !CONVERTER_ENABLE_BIT) begin
      CONVERSION_START_BIT <= 1'b0;
    end else if (complete && !FREE_RUN) begin
      CONVERSION_START_BIT <= 1'b0;
    end else if (kick) begin
      CONVERSION_START_BIT <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      RESULT <= '0;
    end else if (complete) begin
      RESULT <= samp_hold_reg;
    end
  end

  // Set beats clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      CONVERSION_DONE_FLAG <= 1'b0;
    end else if (complete) begin
      CONVERSION_DONE_FLAG <= 1'b1;
    end else if (DONE_FLAG_CLEAR) begin
      CONVERSION_DONE_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      CONVERTER_ACTIVE <= 1'b0;
    end else begin
      CONVERTER_ACTIVE <= (state_reg == SNC_CONV);
    end
  end

  // ==========================================================
  // Wake and interrupt request
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sleep_conv_reg <= 1'b0;
    end else if (sleep_trig) begin
      sleep_conv_reg <= 1'b1;
    end else if (complete) begin
      sleep_conv_reg <= 1'b0;
    end
  end

  // Request stays asserted through an earlier foreign wake
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      DONE_IRQ <= 1'b0;
    end else begin
      DONE_IRQ <= DONE_IRQ_ENABLE &&
                  (CONVERSION_DONE_FLAG || complete);
    end
  end

  // Wake is a pulse; core stays active until its next sleep
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      CORE_WAKE <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      CORE_WAKE <= complete && sleep_conv_reg && DONE_IRQ_ENABLE
                   && CORE_HALTED;
      pend_reg  <= sleep_conv_reg && OTHER_WAKE;
    end
  end

  // ==========================================================
  // Checks
  a_sleep_starts_bit: assert property (@(posedge SYS_CLK) disable iff (SRST)
    sleep_trig |=> CONVERSION_START_BIT)
    else $error("sleep halt did not arm start bit");
  a_start_on_tick: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_reg == SNC_IDLE && CONVERSION_START_BIT && tick
     && CONVERTER_ENABLE_BIT) |=> state_reg == SNC_CONV)
    else $error("conversion not started on converter tick");
  a_done_sets_flag: assert property (@(posedge SYS_CLK) disable iff (SRST)
    complete |=> CONVERSION_DONE_FLAG && RESULT == $past(samp_hold_reg))
    else $error("completion did not set flag and result");
  a_single_clears: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (complete && !FREE_RUN) |=> !CONVERSION_START_BIT)
    else $error("start bit not cleared at completion");
  a_wake_on_done: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (complete && sleep_conv_reg && DONE_IRQ_ENABLE && CORE_HALTED)
    |=> CORE_WAKE ##1 !CORE_WAKE)
    else $error("wake not a single pulse after completion");
  a_irq_pending: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (complete && DONE_IRQ_ENABLE) |=> DONE_IRQ)
    else $error("completion request lost");
  a_enable_kept: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (CORE_HALTED && !nr_sleep && CONVERSION_START_BIT
     && CONVERTER_ENABLE_BIT) |=> CONVERSION_START_BIT || $past(complete))
    else $error("converter stopped in other sleep state");
  a_first_long: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_reg == SNC_IDLE && !$past(CONVERTER_ENABLE_BIT)
     && CONVERTER_ENABLE_BIT) |-> first_reg)
    else $error("first conversion not extended after enable");
  c_sleep_conv: cover property (@(posedge SYS_CLK) sleep_trig ##[1:400] CORE_WAKE);
  c_other_wake: cover property (@(posedge SYS_CLK) pend_reg ##[1:400] DONE_IRQ);
  c_free_run: cover property (@(posedge SYS_CLK) complete && FREE_RUN);
endmodule
`default_nettype wire

// ===== include/snc_cfg.svh
// Constants for the sleep noise canceler block.
// Assumes one 100 MHz clock, synchronous active-high reset.
//
// How it works
// - Noise-reduction or idle sleep with converter armed starts a conversion once halted.
// - With no other wake source, completion interrupt wakes the core.
// - Other interrupt wakes first; completion request still raised when conversion ends.
// - After waking, core stays active until a new sleep instruction.
// - Other sleep states never clear the converter enable.
// - Completion writes result, sets done flag, clears start bit same cycle unless FREE_RUN.
`ifndef SNC_CFG_SVH
`define SNC_CFG_SVH
`define SNC_RES_W        10
`define SNC_CONV_FIRST   25
`define SNC_CONV_NORMAL  13
`define SNC_PRESCALE     8
`define SNC_SLEEP_IDLE   3'h0
`define SNC_SLEEP_NRED   3'h1
`endif

// ===== include/snc_pkg.sv
// Types for the sleep noise canceler block.
// Assumes snc_cfg.svh is on the include path.
package snc_pkg;
  typedef enum logic [2:0] {
    SNC_IDLE = 3'b001,
    SNC_CONV = 3'b010,
    SNC_DONE = 3'b100
  } snc_state_t;
endpackage

// ===== design/snc_tick_div.sv
// Clock enable divider for the converter clock.
// Assumes a single system clock and synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module snc_tick_div #(
  parameter int DIV = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [15:0] cnt_reg;

  initial begin
    if (DIV < 1 || DIV > 65535) $error("snc_tick_div: DIV out of range");
  end

  always_ff @(posedge clk) begin
    if (rst || cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == 16'(DIV - 1));
    end
  end
endmodule
`default_nettype wire

// ===== sim/snc_core_model.sv
// Core and sleep controller model facing the converter control.
// Assumes the bench pulses sleep_go and irq_other after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module snc_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sleep_go,
  input  wire logic [2:0] sleep_code,
  input  wire logic       irq_other,
  input  wire logic       core_wake,
  output logic            halted,
  output logic [2:0]      sleep_sel,
  output logic            other_wake
);
  // ==========================================================
  // Halt and wake
  always_ff @(posedge clk) begin
    if (rst) begin
      halted     <= 1'h0;
      sleep_sel  <= 3'h7;
      other_wake <= 1'h0;
    end else begin
      other_wake <= irq_other & halted;
      if (sleep_go) begin
        halted    <= 1'h1;
        sleep_sel <= sleep_code;
      end else if (core_wake | irq_other) begin
        halted <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Bench for the sleep noise canceler with a core model.
// Assumes snc_cfg.svh on the include path; PRESCALE cut to 2.
`timescale 1ns/100ps
`default_nettype none
`include "snc_cfg.svh"
module tb_top;
  logic sys_clk = 0, srst = 1, en = 0, irq_en = 0, start_wr = 0;
  logic flag_clr = 0, sleep_go = 0, irq_other = 0, free_run = 0;
  logic [2:0] code = 3'h0;
  logic [`SNC_RES_W-1:0] sample = '0, result;
  logic halted, other_wake, start_bit, done_flag, done_irq, wake, active;
  logic [2:0] sel;
  int n_errors = 0, checks = 0, cycles = 0, n_wake = 0;
  always #5 sys_clk = ~sys_clk;
  snc_top #(.PRESCALE(2)) u_snc_top (.SYS_CLK(sys_clk), .SRST(srst),
    .CONVERTER_ENABLE_BIT(en), .FREE_RUN(free_run),
    .DONE_IRQ_ENABLE(irq_en),
    .START_WRITE(start_wr), .CORE_HALTED(halted), .SLEEP_SEL(sel),
    .OTHER_WAKE(other_wake), .DONE_FLAG_CLEAR(flag_clr),
    .ANALOG_SAMPLE(sample), .CONVERSION_START_BIT(start_bit),
    .CONVERSION_DONE_FLAG(done_flag), .DONE_IRQ(done_irq),
    .CORE_WAKE(wake), .CONVERTER_ACTIVE(active), .RESULT(result));
  snc_core_model u_snc_core_model (.clk(sys_clk), .rst(srst),
    .sleep_go(sleep_go), .sleep_code(code), .irq_other(irq_other),
    .core_wake(wake), .halted(halted), .sleep_sel(sel),
    .other_wake(other_wake));
  // ==========================================================
  // Tasks
  task automatic wrap_up();
    $display("counts: %0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    step();
    s = 1'h0;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'h1; i++) step();
  endtask
  task automatic go_sleep(input logic [2:0] c);
    code = c;
    pulse(sleep_go);
  endtask
  task automatic clear_flag();
    pulse(flag_clr);
    step();
    check("flag cleared", done_flag, 16'h0);
    check("irq cleared", done_irq, 16'h0);
  endtask
  // Sleep kicks a conversion; optionally another source wakes first
  task automatic run_conv(logic [2:0] c, logic [9:0] v, bit other);
    sample = v;
    n_wake = 0;
    go_sleep(c);
    wait_hi(start_bit, 4);
    check("start bit", start_bit, 16'h1);
    repeat (3) step();
    check("converting", active, 16'h1);
    if (other) pulse(irq_other);
    wait_hi(done_flag, 120);
    check("done flag", done_flag, 16'h1);
    check("result", result, v);
    check("start cleared", start_bit, 16'h0);
    repeat (3) step();
    check("conv idle", active, 16'h0);
    check("irq", done_irq, 16'h1);
    check("wakes", n_wake, other ? 16'h0 : 16'h1);
    repeat (6) step();
    check("core active", halted, 16'h0);
    clear_flag();
  endtask
  // ==========================================================
  // Timeout and wake counting
  always @(posedge sys_clk) begin
    cycles++;
    if (wake === 1'h1) n_wake++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // Tests; no reference or channel control at these ports
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    srst = 0;
    en = 1;
    irq_en = 1;
    run_conv(3'h1, 10'h2A5, 0);
    $display("test noise reduction sleep done");
    run_conv(3'h0, 10'h15A, 0);
    $display("test idle sleep done");
    run_conv(3'h1, 10'h3FF, 1);
    $display("test other wake first done");
    go_sleep(3'h2);
    repeat (6) step();
    check("no kick", start_bit, 16'h0);
    sample = 10'h0C3;
    pulse(start_wr);
    wait_hi(done_flag, 60);
    check("still enabled", result, 16'h0C3);
    pulse(irq_other);
    clear_flag();
    $display("test other sleep done");
    free_run = 1;
    pulse(start_wr);
    wait_hi(done_flag, 60);
    check("free run start", start_bit, 16'h1);
    free_run = 0;
    clear_flag();
    wait_hi(done_flag, 60);
    check("free run stop", start_bit, 16'h0);
    clear_flag();
    $display("test free run done");
    en = 0;
    go_sleep(3'h1);
    repeat (6) step();
    check("disabled", start_bit, 16'h0);
    pulse(irq_other);
    $display("test disabled sleep done");
    wrap_up();
  end
endmodule
`default_nettype wire
